// *** design/tick_core_if.sv ***
// Carrier between the register front end and the counter core.
`timescale 1ns/1ps
interface tick_core_if;
  logic       tick;
  logic       run_wr;
  logic       run_wdata;
  logic       one_shot;
  logic [7:0] cmp;
  logic       clr;
  logic       flag_clr;
  logic [7:0] cnt;
  logic       run;
  logic       flag;
  modport regs (output tick, run_wr, run_wdata, one_shot, cmp, clr, flag_clr, input cnt, run, flag);
  modport core (input tick, run_wr, run_wdata, one_shot, cmp, clr, flag_clr, output cnt, run, flag);
endinterface

// *** design/tick_counter_core.sv ***
// Counter core: run control, counter, compare match and sticky flag.
`timescale 1ns/1ps
module tick_counter_core
  import tick_timer_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  tick_core_if.core cif
);
  logic       tick_d_r;
  logic       tick_d_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic       run_r;
  logic       run_nxt;
  logic       flag_r;
  logic       flag_nxt;
  logic       tick_edge;
  logic       hit;

  always_comb begin
    tick_edge  = cif.tick & ~tick_d_r;
    hit        = run_r & tick_edge & (cnt_r == cif.cmp) & ~cif.clr;
    tick_d_nxt = cif.tick;
    cnt_nxt    = cnt_r;
    if (cif.clr) begin
      cnt_nxt = CNT_RST; // R1
    end else if (run_r & tick_edge) begin
      cnt_nxt = hit ? CNT_RST : cnt_r + CNT_STEP; // R9
    end
    run_nxt = run_r;
    if (hit & cif.one_shot) begin
      run_nxt = 1'b0; // R2
    end
    // A software write in the halting cycle wins, so a restart is never lost.
    if (cif.run_wr) begin
      run_nxt = cif.run_wdata; // R3
    end
    flag_nxt = flag_r;
    if (cif.flag_clr) begin
      flag_nxt = 1'b0; // R8
    end
    // The hardware set outranks the clear so that no match is lost.
    if (hit) begin
      flag_nxt = 1'b1; // R7
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_d_r <= 1'b0;
      cnt_r    <= CNT_RST;
      run_r    <= BIT_RST;
      flag_r   <= BIT_RST;
    end else begin
      tick_d_r <= tick_d_nxt;
      cnt_r    <= cnt_nxt;
      run_r    <= run_nxt;
      flag_r   <= flag_nxt;
    end
  end

  assign cif.cnt  = cnt_r;
  assign cif.run  = run_r;
  assign cif.flag = flag_r;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_match_wraps: assert property (hit |=> cnt_r == 8'h00 && flag_r) // R9
    else $error("Compare match did not wrap counter and set flag.");
  a_count_steps: assert property (run_r && tick_edge && !cif.clr && cnt_r != cif.cmp // R9
                                  |=> cnt_r == $past(cnt_r) + 8'h01)
    else $error("Counter did not advance by one on a tick.");
  a_oneshot_halts: assert property (hit && cif.one_shot && !cif.run_wr |=> !run_r) // R2
    else $error("Single-shot mode kept running after the match.");
  a_repeat_runs: assert property (hit && !cif.one_shot && !cif.run_wr |=> run_r) // R2
    else $error("Repeat mode stopped after the match.");
  a_flag_sticky: assert property (flag_r && !cif.flag_clr |=> flag_r) // R7
    else $error("Flag dropped without a clear.");
  a_flag_clear: assert property (cif.flag_clr && !hit |=> !flag_r) // R8
    else $error("Write of one did not clear the flag.");
  a_stopped_holds: assert property (!run_r && !cif.clr |=> cnt_r == $past(cnt_r)) // R3
    else $error("Counter moved while stopped.");

  c_oneshot_done: cover property (hit && cif.one_shot ##1 !run_r);
  c_repeat_wrap: cover property (hit && !cif.one_shot ##[1:600] hit);
  c_set_beats_clear: cover property (hit && cif.flag_clr);
endmodule

// *** design/tick_reset_sync.sv ***
// Reset synchroniser: asynchronous assertion, release through two flip-flops.
`timescale 1ns/1ps
module tick_reset_sync (
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  output logic      o_rst_n
);
  logic meta_r;
  logic meta_nxt;
  logic rst_r;
  logic rst_nxt;

  always_comb begin
    meta_nxt = 1'b1;
    rst_nxt  = meta_r;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_r <= 1'b0;
      rst_r  <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      rst_r  <= rst_nxt;
    end
  end

  assign o_rst_n = rst_r;
endmodule

// *** design/tick_timer.sv ***
// Top of the low-speed 8-bit tick timer with its Avalon-MM register slave.
//
// How it works
// R1: Writing one to bit 4 clears counter.
// R2: Bit 1 picks single-shot or repeat counting.
// R3: Bit 0 starts and stops the counter.
// R4: Counter value readable, eight bits, resets zero.
// R5: Compare value read/write, sets the period.
// R6: Mask bit 0 gates the interrupt request.
// R7: Flag bit 0 sets on match, sticky.
// R8: Write one clears flag; unused bits read zero.
// R9: Count ticks, match sets flag, wraps, halts.
`timescale 1ns/1ps
module tick_timer
  import tick_timer_pkg::*;
(
  input  wire logic                              I_CLK,
  input  wire logic                              I_ARST_N,
  input  wire logic                              I_LS_TICK,
  input  wire logic [tick_timer_pkg::ADDR_W-1:0] I_AVS_ADDRESS,
  input  wire logic                              I_AVS_READ,
  input  wire logic                              I_AVS_WRITE,
  input  wire logic [31:0]                       I_AVS_WRITEDATA,
  input  wire logic [3:0]                        I_AVS_BYTEENABLE,
  output logic      [31:0]                       O_AVS_READDATA,
  output logic                                   O_AVS_WAITREQUEST,
  output logic                                   O_TICK_IRQ
);
  import tick_timer_pkg::*;

  // ********************************************************************
  // Reset and carrier
  // ********************************************************************

  logic rst_n;

  tick_reset_sync u_rst (
    .i_clk    (I_CLK),
    .i_arst_n (I_ARST_N),
    .o_rst_n  (rst_n)
  );

  tick_core_if cif ();

  tick_counter_core u_core (
    .i_clk   (I_CLK),
    .i_rst_n (rst_n),
    .cif     (cif.core)
  );

  // ********************************************************************
  // Bus handshake state
  // ********************************************************************

  bus_state_type state_r;
  bus_state_type state_nxt;
  logic          waitreq_r;
  logic          waitreq_nxt;
  logic [31:0]   rdata_r;
  logic [31:0]   rdata_nxt;

  // ********************************************************************
  // Software-owned control state and the interrupt output register
  // ********************************************************************

  logic       mode_r;
  logic       mode_nxt;
  logic [7:0] cmp_r;
  logic [7:0] cmp_nxt;
  logic       ie_r;
  logic       ie_nxt;
  logic       irq_r;
  logic       irq_nxt;

  // ********************************************************************
  // Decode
  // ********************************************************************

  logic       req;
  logic       take;
  logic       wr_go;
  logic       hit_ctl;
  logic       hit_cnt;
  logic       hit_cmp;
  logic       hit_mask;
  logic       hit_flag;
  logic [7:0] rd_byte;

  always_comb begin
    req      = I_AVS_READ | I_AVS_WRITE;
    hit_ctl  = reg_hit(I_AVS_ADDRESS, IDX_CTL);
    hit_cnt  = reg_hit(I_AVS_ADDRESS, IDX_CNT);
    hit_cmp  = reg_hit(I_AVS_ADDRESS, IDX_CMP);
    hit_mask = reg_hit(I_AVS_ADDRESS, IDX_MASK);
    hit_flag = reg_hit(I_AVS_ADDRESS, IDX_FLAG);
    // The master samples waitrequest low at the edge that ends the ACK state.
    take     = (state_r == BUS_ACK) & req;
    // Only byte lane 0 carries register data; other lanes are ignored.
    wr_go    = take & I_AVS_WRITE & I_AVS_BYTEENABLE[0];
  end

  // Read mux: unused upper bits and the write-only clear bit read as zero.
  always_comb begin
    rd_byte = 8'h00;
    if (hit_ctl) begin
      rd_byte[CTL_RUN_BIT]  = cif.run; // R3
      rd_byte[CTL_MODE_BIT] = mode_r; // R2
    end else if (hit_cnt) begin
      rd_byte = cif.cnt; // R4
    end else if (hit_cmp) begin
      rd_byte = cmp_r; // R5
    end else if (hit_mask) begin
      rd_byte[IRQ_BIT] = ie_r; // R6
    end else if (hit_flag) begin
      rd_byte[IRQ_BIT] = cif.flag; // R7
    end
  end

  // ********************************************************************
  // Bus handshake
  // ********************************************************************

  // One wait state: the request is seen in IDLE, answered in ACK.
  // Read data are captured at the first edge and stand while waitrequest is low.
  always_comb begin
    state_nxt = state_r;
    rdata_nxt = rdata_r;
    unique case (state_r)
      BUS_IDLE: begin
        if (req) begin
          state_nxt = BUS_ACK;
          if (I_AVS_READ) begin
            rdata_nxt = {24'h00_0000, rd_byte}; // R8
          end
        end
      end
      BUS_ACK: begin
        state_nxt = BUS_IDLE;
      end
    endcase
    waitreq_nxt = (state_nxt != BUS_ACK);
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= BUS_IDLE;
      waitreq_r <= 1'b1;
      rdata_r   <= RDATA_RST;
    end else begin
      state_r   <= state_nxt;
      waitreq_r <= waitreq_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // ********************************************************************
  // Control registers and core strobes
  // ********************************************************************

  always_comb begin
    mode_nxt = mode_r;
    cmp_nxt  = cmp_r;
    ie_nxt   = ie_r;
    if (wr_go & hit_ctl) begin
      mode_nxt = I_AVS_WRITEDATA[CTL_MODE_BIT]; // R2
    end
    if (wr_go & hit_cmp) begin
      cmp_nxt = I_AVS_WRITEDATA[7:0]; // R5
    end
    if (wr_go & hit_mask) begin
      ie_nxt = I_AVS_WRITEDATA[IRQ_BIT]; // R6
    end
    // Registered so the output pin never glitches on the gate.
    irq_nxt = cif.flag & ie_r; // R6
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= BIT_RST;
      cmp_r  <= CMP_RST;
      ie_r   <= BIT_RST;
      irq_r  <= BIT_RST;
    end else begin
      mode_r <= mode_nxt;
      cmp_r  <= cmp_nxt;
      ie_r   <= ie_nxt;
      irq_r  <= irq_nxt;
    end
  end

  assign cif.tick      = I_LS_TICK;
  assign cif.one_shot  = mode_r;
  assign cif.cmp       = cmp_r;
  assign cif.run_wr    = wr_go & hit_ctl; // R3
  assign cif.run_wdata = I_AVS_WRITEDATA[CTL_RUN_BIT];
  assign cif.clr       = wr_go & hit_ctl & I_AVS_WRITEDATA[CTL_CLR_BIT]; // R1
  assign cif.flag_clr  = wr_go & hit_flag & I_AVS_WRITEDATA[IRQ_BIT]; // R8

  assign O_AVS_READDATA    = rdata_r;
  assign O_AVS_WAITREQUEST = waitreq_r;
  assign O_TICK_IRQ        = irq_r;

  // ********************************************************************
  // Checks
  // ********************************************************************

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!rst_n);

  // ********************************************************************
  // Checks: control and counter
  // ********************************************************************

  // Each read-back check compares with the state sampled at the capture edge,
  // one edge before the answer, because read data are registered there.
  a_clear_zeroes_cnt: assert property (cif.clr |=> cif.cnt == 8'h00) // R1
    else $error("Clear write did not zero the counter.");
  a_zero_keeps_cnt: assert property (wr_go && hit_ctl && !I_AVS_WRITEDATA[CTL_CLR_BIT] && !cif.run // R1
                                     |=> cif.cnt == $past(cif.cnt))
    else $error("Control write without the clear bit moved a stopped counter.");
  // A clear in the matching cycle must win, so the flag may not rise with it.
  a_clear_blocks_match: assert property (cif.clr && !cif.flag |=> !cif.flag) // R1
    else $error("Flag set in the same cycle as a counter clear.");
  a_ctl_reads_clean: assert property (take && I_AVS_READ && hit_ctl // R1
                                      |-> O_AVS_READDATA[31:2] == 30'h0)
    else $error("Control read shows clear bit or reserved bits.");
  a_mode_written: assert property (wr_go && hit_ctl // R2
                                   |=> mode_r == $past(I_AVS_WRITEDATA[1]))
    else $error("Mode bit did not take the written value.");
  a_mode_holds: assert property (!(wr_go && hit_ctl) |=> mode_r == $past(mode_r)) // R2
    else $error("Mode bit changed without a control write.");
  a_run_written: assert property (wr_go && hit_ctl // R3
                                  |=> cif.run == $past(I_AVS_WRITEDATA[0]))
    else $error("Run bit did not take the written value.");
  a_run_holds: assert property (!(wr_go && hit_ctl) && !cif.run |=> !cif.run) // R3
    else $error("Stopped timer started without a control write.");
  a_ctl_readback: assert property (take && I_AVS_READ && hit_ctl // R3
                                   |-> O_AVS_READDATA[1:0] == $past({mode_r, cif.run}))
    else $error("Control read did not show the mode and run bits.");
  a_cnt_readback: assert property (state_r == BUS_IDLE && I_AVS_READ && hit_cnt // R4
                                   |=> O_AVS_READDATA == {24'h00_0000, $past(cif.cnt)})
    else $error("Counter read returned a wrong value.");
  // Read data must stand until the next read is captured.
  a_rdata_holds: assert property (!(state_r == BUS_IDLE && I_AVS_READ) // R4
                                  |=> O_AVS_READDATA == $past(O_AVS_READDATA))
    else $error("Read data changed without a new read.");
  // A stopped timer never sees a match, so an idle flag stays low.
  a_stopped_no_flag: assert property (!cif.run && !cif.flag |=> !cif.flag) // R9
    else $error("Flag set while the timer was stopped.");

  // ********************************************************************
  // Checks: compare and mask
  // ********************************************************************

  // A write with lane 0 disabled is answered but must leave every register alone.
  a_cmp_written: assert property (wr_go && hit_cmp // R5
                                  |=> cmp_r == $past(I_AVS_WRITEDATA[7:0]))
    else $error("Compare value did not take the written byte.");
  a_cmp_holds: assert property (!(wr_go && hit_cmp) |=> cmp_r == $past(cmp_r)) // R5
    else $error("Compare value changed without a compare write.");
  a_cmp_readback: assert property (take && I_AVS_READ && hit_cmp // R5
                                   |-> O_AVS_READDATA == {24'h00_0000, $past(cmp_r)})
    else $error("Compare read returned a wrong value.");
  a_lane_gates_write: assert property (take && I_AVS_WRITE && !I_AVS_BYTEENABLE[0] // R5
                                       |=> cmp_r == $past(cmp_r) && ie_r == $past(ie_r)
                                           && mode_r == $past(mode_r))
    else $error("Write with lane 0 disabled changed a register.");
  a_ie_written: assert property (wr_go && hit_mask // R6
                                 |=> ie_r == $past(I_AVS_WRITEDATA[0]))
    else $error("Mask bit did not take the written value.");
  a_ie_holds: assert property (!(wr_go && hit_mask) |=> ie_r == $past(ie_r)) // R6
    else $error("Mask bit changed without a mask write.");
  a_mask_readback: assert property (take && I_AVS_READ && hit_mask // R6
                                    |-> O_AVS_READDATA == {31'h0, $past(ie_r)})
    else $error("Mask read returned a wrong value.");
  // The interrupt pin lags the flag and the mask by its one output register.
  a_irq_gated: assert property (##1 O_TICK_IRQ == $past(cif.flag && ie_r)) // R6
    else $error("Interrupt output not gated by the mask bit.");
  a_irq_masked_low: assert property (!ie_r |=> !O_TICK_IRQ) // R6
    else $error("Interrupt output rose while masked.");

  // ********************************************************************
  // Checks: flag and bus answer
  // ********************************************************************

  a_flag_reads_back: assert property (take && I_AVS_READ && hit_flag // R7
                                      |-> O_AVS_READDATA == {31'h0, $past(cif.flag)})
    else $error("Flag read returned a wrong value.");
  a_flag_zero_keeps: assert property (wr_go && hit_flag && !I_AVS_WRITEDATA[IRQ_BIT] && cif.flag // R8
                                      |=> cif.flag)
    else $error("Writing zero to the flag cleared it.");
  // Holes in the map are answered like registers, so software never hangs on them.
  a_unmapped_zero: assert property (take && I_AVS_READ // R8
                                    && !(hit_ctl || hit_cnt || hit_cmp || hit_mask || hit_flag)
                                    |-> O_AVS_READDATA == 32'h0000_0000)
    else $error("Read of an unmapped address did not return zero.");
  // A new request may follow right after the answer, so waitrequest must rise again.
  a_one_wait: assert property (state_r == BUS_IDLE && req // R8
                               |=> !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST)
    else $error("Bus answer did not come after exactly one wait state.");

  c_read_cnt: cover property (take && I_AVS_READ && hit_cnt);
  c_irq_rises: cover property (!O_TICK_IRQ ##1 O_TICK_IRQ);
  c_flag_cleared: cover property (cif.flag_clr);
endmodule

// *** design/tick_timer_pkg.sv ***
// Constants, types and helpers shared by the tick timer design.
package tick_timer_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned ADDR_W        = 17;
  localparam int unsigned IDX_W         = 15;
  // Printed register offsets are indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_CTL  = 15'h50c0;
  localparam logic [IDX_W-1:0] IDX_CNT  = 15'h50c1;
  localparam logic [IDX_W-1:0] IDX_CMP  = 15'h50c2;
  localparam logic [IDX_W-1:0] IDX_MASK = 15'h50c3;
  localparam logic [IDX_W-1:0] IDX_FLAG = 15'h50c4;
  localparam int unsigned CTL_RUN_BIT  = 0;
  localparam int unsigned CTL_MODE_BIT = 1;
  localparam int unsigned CTL_CLR_BIT  = 4;
  localparam int unsigned IRQ_BIT      = 0;
  localparam logic [7:0]  CNT_RST      = 8'h00;
  localparam logic [7:0]  CMP_RST      = 8'h00;
  localparam logic        BIT_RST      = 1'b0;
  localparam logic [31:0] RDATA_RST    = 32'h0000_0000;
  localparam logic [7:0]  CNT_STEP     = 8'h01;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_type;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [IDX_W-1:0] idx);
    return a == {idx, 2'b00};
  endfunction
endpackage

// *** sim/tick_timer_tb.sv ***
// Self-checking bench for the low-speed tick timer.
`timescale 1ns/1ps
module tick_timer_tb;
  import tick_timer_pkg::*;
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
  logic              i_clk     = 1'b0;
  logic              i_arst_n  = 1'b0;
  logic              ls_tick   = 1'b0;
  logic [ADDR_W-1:0] avs_addr  = '0;
  logic              avs_read  = 1'b0;
  logic              avs_write = 1'b0;
  logic [31:0]       avs_wdat  = '0;
  logic [3:0]        avs_be    = '0;
  logic [31:0]       avs_rdat;
  logic              avs_wait;
  logic              tick_irq;
  logic [32:0]       exp_q[$];
  logic [32:0]       exp_now;
  logic [31:0]       seed      = 32'd93;
  logic [7:0]        cmp_v;
  int                failures  = 0;
  int                checked   = 0;

  tick_timer dut (
    .I_CLK             (i_clk),
    .I_ARST_N          (i_arst_n),
    .I_LS_TICK         (ls_tick),
    .I_AVS_ADDRESS     (avs_addr),
    .I_AVS_READ        (avs_read),
    .I_AVS_WRITE       (avs_write),
    .I_AVS_WRITEDATA   (avs_wdat),
    .I_AVS_BYTEENABLE  (avs_be),
    .O_AVS_READDATA    (avs_rdat),
    .O_AVS_WAITREQUEST (avs_wait),
    .O_TICK_IRQ        (tick_irq)
  );

  initial begin
    forever #5 i_clk = ~i_clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // ****************************************
  // Bus master and result watcher
  // ****************************************
  // Upper write data bits are random so that a design using them shows up.
  task automatic bus(input logic is_wr, input logic [IDX_W-1:0] idx, input logic [7:0] v, input logic [3:0] be);
    int          n;
    logic [31:0] r;
    n = 0;
    r = xs();
    @(posedge i_clk);
    avs_addr  <= {idx, 2'b00};
    avs_wdat  <= {r[31:8], v};
    avs_be    <= be;
    avs_write <= is_wr;
    avs_read  <= !is_wr;
    do begin
      @(posedge i_clk);
      n++;
    end while (avs_wait && n < 50);
    if (n >= 50) failures++;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] v);
    bus(1'b1, idx, v, 4'hf);
  endtask

  task automatic rd(input logic [IDX_W-1:0] idx, input logic [7:0] v, input logic irq);
    exp_q.push_back({irq, 24'h000000, v});
    bus(1'b0, idx, 8'h00, 4'hf);
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge i_clk);
      ls_tick <= 1'b1;
      repeat (2) @(posedge i_clk);
      ls_tick <= 1'b0;
    end
  endtask

  always @(posedge i_clk) begin
    if (avs_read && !avs_wait) begin
      exp_now = exp_q.pop_front();
      `CHK({tick_irq, avs_rdat}, exp_now)
    end
  end

  task automatic close_out();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_clk);
    failures++;
    close_out();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (6) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    rd(IDX_CTL, 8'h00, 1'b0);
    rd(IDX_CNT, 8'h00, 1'b0);
    rd(IDX_CMP, 8'h00, 1'b0);
    rd(IDX_MASK, 8'h00, 1'b0);
    rd(IDX_FLAG, 8'h00, 1'b0);
    rd(15'h50c5, 8'h00, 1'b0);
    $display("test reset_values done");
    cmp_v = 8'h03 + 8'(xs() & 32'h0000000f);
    wr(IDX_CMP, cmp_v);
    rd(IDX_CMP, cmp_v, 1'b0);
    wr(IDX_MASK, 8'hff);
    rd(IDX_MASK, 8'h01, 1'b0);
    wr(IDX_CTL, 8'h01);
    ticks(cmp_v);
    rd(IDX_CNT, cmp_v, 1'b0);
    rd(IDX_FLAG, 8'h00, 1'b0);
    ticks(1);
    rd(IDX_CNT, 8'h00, 1'b1);
    rd(IDX_FLAG, 8'h01, 1'b1);
    $display("test repeat_period done");
    wr(IDX_FLAG, 8'h00);
    rd(IDX_FLAG, 8'h01, 1'b1);
    wr(IDX_FLAG, 8'h01);
    rd(IDX_FLAG, 8'h00, 1'b0);
    $display("test flag_clear done");
    ticks(2);
    rd(IDX_CNT, 8'h02, 1'b0);
    wr(IDX_CTL, 8'h11);
    rd(IDX_CNT, 8'h00, 1'b0);
    rd(IDX_CTL, 8'h01, 1'b0);
    bus(1'b1, IDX_CMP, 8'h00, 4'he);
    rd(IDX_CMP, cmp_v, 1'b0);
    wr(IDX_CTL, 8'h00);
    ticks(2);
    rd(IDX_CNT, 8'h00, 1'b0);
    $display("test clear_and_stop done");
    wr(IDX_MASK, 8'h00);
    wr(IDX_CTL, 8'h03);
    ticks(cmp_v + 1);
    rd(IDX_CTL, 8'h02, 1'b0);
    rd(IDX_FLAG, 8'h01, 1'b0);
    ticks(2);
    rd(IDX_CNT, 8'h00, 1'b0);
    $display("test one_shot done");
    close_out();
  end
endmodule
